// ---- rtl/sdcf_lamp.sv ----
`timescale 1ns/10ps
module sdcf_lamp #(
  parameter logic [29:0] PERIOD_CYCLES = 30'(sdcf_pkg::LAMP_PERIOD_CYC),
  parameter logic [29:0] ON_CYCLES = 30'(sdcf_pkg::LAMP_ON_CYC),
  parameter logic [29:0] OFF_CYCLES = 30'(sdcf_pkg::LAMP_OFF_CYC)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] flash_count,
  output logic lamp
);
  typedef enum logic [3:0] {
    LAMP_DARK = 4'b0001,
    LAMP_LIT = 4'b0010,
    LAMP_GAP = 4'b0100,
    LAMP_REST = 4'b1000
  } sdcf_lamp_type;

  sdcf_lamp_type state;
  sdcf_lamp_type next_state;
  logic [29:0] period_cnt;
  logic [29:0] phase_cnt;
  logic [2:0] flashes_left;
  logic period_end;
  logic phase_end;

  assign period_end = period_cnt == PERIOD_CYCLES - 30'd1;
  assign phase_end = (state == LAMP_LIT) ? phase_cnt == ON_CYCLES - 30'd1 :
                     phase_cnt == OFF_CYCLES - 30'd1;

  always_comb begin
    next_state = state;
    case (state)
      LAMP_DARK: begin
        if (flash_count != 3'h0) begin
          next_state = LAMP_LIT;
        end
      end
      LAMP_LIT: begin
        if (phase_end) begin
          next_state = LAMP_GAP;
        end
      end
      LAMP_GAP: begin
        if (phase_end) begin
          next_state = (flashes_left != 3'h0) ? LAMP_LIT : LAMP_REST;
        end
      end
      LAMP_REST: begin
        if (period_end) begin
          next_state = LAMP_LIT;
        end
      end
      default: next_state = LAMP_DARK;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= LAMP_DARK;
      period_cnt <= 30'h0000_0000;
      phase_cnt <= 30'h0000_0000;
      flashes_left <= 3'h0;
      lamp <= 1'b0;
    end else begin
      state <= next_state;
      lamp <= next_state == LAMP_LIT;
      // period restarts with the first flash of each pattern
      if (state == LAMP_DARK || period_end) begin
        period_cnt <= 30'h0000_0000;
      end else begin
        period_cnt <= period_cnt + 30'd1;
      end
      if (next_state != state) begin
        phase_cnt <= 30'h0000_0000;
      end else begin
        phase_cnt <= phase_cnt + 30'd1;
      end
      if (next_state == LAMP_LIT && state != LAMP_LIT) begin
        flashes_left <= (state == LAMP_GAP) ? flashes_left - 3'd1 :
                        flash_count - 3'd1;
      end
    end
  end
endmodule

// ---- rtl/sdcf_pkg.sv ----
package sdcf_pkg;
  // clock and timing
  localparam int CLK_HZ = 250_000_000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int DIR_SETUP_NS = 5000;
  localparam int PULSE_MIN_NS = 2500;
  localparam int IDLE_MS = 1000;
  localparam int LAMP_PERIOD_MS = 3000;
  localparam int LAMP_ON_MS = 250;
  localparam int LAMP_OFF_MS = 360;
  // least times round up
  localparam int DIR_SETUP_CYC = (DIR_SETUP_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam int IDLE_CYC = IDLE_MS * (CLK_HZ / 1000);
  localparam int LAMP_PERIOD_CYC = LAMP_PERIOD_MS * (CLK_HZ / 1000);
  localparam int LAMP_ON_CYC = LAMP_ON_MS * (CLK_HZ / 1000);
  localparam int LAMP_OFF_CYC = LAMP_OFF_MS * (CLK_HZ / 1000);
  localparam int LONG_W = 30;
  localparam int AGE_W = 11;

  // register map, byte addresses
  localparam int ADDR_W = 5;
  localparam logic [4:0] REG_CONTROL = 5'h00;
  localparam logic [4:0] REG_SW_RESOLUTION = 5'h04;
  localparam logic [4:0] REG_SW_CURRENT = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0c;
  localparam logic [4:0] REG_RESOLUTION = 5'h10;
  localparam logic [4:0] REG_CURRENT = 5'h14;
  localparam logic [4:0] REG_POSITION = 5'h18;
  // control fields
  localparam int CTRL_DUAL_BIT = 0;
  localparam int CTRL_FALLING_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // status fields
  localparam int ST_OC_BIT = 0;
  localparam int ST_OV_BIT = 1;
  localparam int ST_PE_BIT = 2;
  localparam int ST_TIMING_BIT = 3;
  localparam int ST_IDLE_BIT = 4;
  localparam int ST_RUN_BIT = 5;

  // resolution, steps per revolution
  localparam int RES_W = 17;
  localparam logic [31:0] RES_MIN = 32'h0000_00c8;
  localparam logic [31:0] RES_MAX = 32'h0001_9000;
  localparam logic [16:0] RES_BASE = 17'h0_00c8;
  localparam logic [16:0] SW_RES_RESET = 17'h0_00c8;
  localparam logic [16:0] RES_DECADE [8] = '{17'h0_03e8, 17'h0_07d0,
    17'h0_0fa0, 17'h0_1388, 17'h0_1f40, 17'h0_2710, 17'h0_4e20,
    17'h0_61a8};
  // current in milliamps
  localparam int CUR_W = 14;
  localparam logic [31:0] CUR_MIN = 32'h0000_01f4;
  localparam logic [31:0] CUR_MAX = 32'h0000_206c;
  localparam logic [13:0] SW_CUR_RESET = 14'h0c80;
  localparam logic [13:0] CUR_TABLE [8] = '{14'h0000, 14'h0c80,
    14'h0fa0, 14'h1324, 14'h1644, 14'h1900, 14'h1c84, 14'h206c};
endpackage

// ---- rtl/sdcf_sync.sv ----
`timescale 1ns/10ps
module sdcf_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ---- rtl/sdcf_top.sv ----
`timescale 1ns/10ps
// Summary of operation
// - outside software mode, resolution comes only from four switch bits
// - all four resolution bits on selects the software resolution value
// - group on: index from off bits, 200 times two to the index
// - group off: index picks 1000 up to 25000 steps per revolution
// - all current bits off selects the software dynamic current
// - current index from on bits picks 3.2 A up to 8.3 A
// - standstill current is half dynamic when off, equal when on
// - current drops to the lower of standstill and sixty percent one second after the last step
// - fault lamp repeats a flash pattern every 3 s
// - over-current fault flashes the lamp once per period
// - over-voltage fault flashes the lamp twice per period
// - phase error fault flashes the lamp four times per period
// - only the highest priority fault is shown: current, voltage, phase
// - any fault frees the shaft and stays latched until power-up
// - step plus direction mode and dual clockwise/counter pulse mode
// - default step plus direction on rising edge, edge selectable
// - step plus direction: direction level gives each step's rotation
// - output stage enabled while the enable input is high and no fault is latched
module sdcf_top #(
  parameter logic [29:0] IDLE_CYCLES = 30'(sdcf_pkg::IDLE_CYC),
  parameter logic [29:0] LAMP_PERIOD_CYCLES = 30'(sdcf_pkg::LAMP_PERIOD_CYC),
  parameter logic [29:0] LAMP_ON_CYCLES = 30'(sdcf_pkg::LAMP_ON_CYC),
  parameter logic [29:0] LAMP_OFF_CYCLES = 30'(sdcf_pkg::LAMP_OFF_CYC)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic current_select_bit0,
  input wire logic current_select_bit1,
  input wire logic current_select_bit2,
  input wire logic standstill_select,
  input wire logic resolution_select_bit0,
  input wire logic resolution_select_bit1,
  input wire logic resolution_select_bit2,
  input wire logic resolution_group_select,
  input wire logic step_pulse_in,
  input wire logic direction_in,
  input wire logic drive_enable_in,
  input wire logic overcurrent_detect,
  input wire logic overvoltage_detect,
  input wire logic phase_error_detect,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic fault_lamp,
  output logic stage_enable,
  output logic step_strobe,
  output logic step_clockwise,
  output logic [13:0] current_command_ma,
  output logic [13:0] standstill_current_ma,
  output logic [16:0] resolution_steps
);
  localparam logic [10:0] SETUP_LIM = 11'(sdcf_pkg::DIR_SETUP_CYC);
  localparam logic [10:0] PULSE_LIM = 11'(sdcf_pkg::PULSE_MIN_CYC);

  function automatic logic [31:0] clamp(input logic [31:0] v,
                                        input logic [31:0] lo,
                                        input logic [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [10:0] sat_inc(input logic [10:0] v,
                                          input logic [10:0] lim);
    sat_inc = (v >= lim) ? lim : v + 11'd1;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [13:0] pins_raw;
  logic [13:0] pins_s;
  logic [2:0] cur_bits;
  logic stand_on;
  logic [2:0] res_bits;
  logic group_on;
  logic step_s;
  logic dir_s;
  logic ena_s;
  logic oc_s;
  logic ov_s;
  logic pe_s;

  assign pins_raw = {current_select_bit2, current_select_bit1,
                     current_select_bit0, standstill_select,
                     resolution_select_bit2, resolution_select_bit1,
                     resolution_select_bit0, resolution_group_select,
                     step_pulse_in, direction_in, drive_enable_in,
                     overcurrent_detect, overvoltage_detect,
                     phase_error_detect};
  assign {cur_bits, stand_on, res_bits, group_on, step_s, dir_s, ena_s,
          oc_s, ov_s, pe_s} = pins_s;

  sdcf_sync #(.WIDTH(14)) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  //////////////////////////////////////////////////////////////////////////
  // registers
  logic ctrl_dual;
  logic ctrl_falling;
  logic [16:0] sw_res;
  logic [13:0] sw_cur;
  logic timing_error;
  logic fault_oc;
  logic fault_ov;
  logic fault_pe;
  logic idle;
  logic running;
  logic [31:0] position;
  logic [31:0] status_word;
  logic [31:0] rd_value;
  logic wr_control;
  logic wr_sw_res;
  logic wr_sw_cur;
  logic clear_timing;

  assign wr_control = reg_write && reg_addr == sdcf_pkg::REG_CONTROL;
  assign wr_sw_res = reg_write && reg_addr == sdcf_pkg::REG_SW_RESOLUTION;
  assign wr_sw_cur = reg_write && reg_addr == sdcf_pkg::REG_SW_CURRENT;
  assign clear_timing = reg_write && reg_addr == sdcf_pkg::REG_STATUS &&
                        reg_wdata[sdcf_pkg::ST_TIMING_BIT];

  assign status_word = {26'h000_0000, running, idle, timing_error, fault_pe,
                        fault_ov, fault_oc};
  assign rd_value =
    (reg_addr == sdcf_pkg::REG_CONTROL) ?
      {30'h0000_0000, ctrl_falling, ctrl_dual} :
    (reg_addr == sdcf_pkg::REG_SW_RESOLUTION) ? {15'h0000, sw_res} :
    (reg_addr == sdcf_pkg::REG_SW_CURRENT) ? {18'h0_0000, sw_cur} :
    (reg_addr == sdcf_pkg::REG_STATUS) ? status_word :
    (reg_addr == sdcf_pkg::REG_RESOLUTION) ? {15'h0000, resolution_steps} :
    (reg_addr == sdcf_pkg::REG_CURRENT) ? {18'h0_0000, current_command_ma} :
    (reg_addr == sdcf_pkg::REG_POSITION) ? position : 32'h0000_0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {ctrl_falling, ctrl_dual} <= sdcf_pkg::CTRL_RESET;
      sw_res <= sdcf_pkg::SW_RES_RESET;
      sw_cur <= sdcf_pkg::SW_CUR_RESET;
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_read ? rd_value : 32'h0000_0000;
      if (wr_control) begin
        ctrl_dual <= reg_wdata[sdcf_pkg::CTRL_DUAL_BIT];
        ctrl_falling <= reg_wdata[sdcf_pkg::CTRL_FALLING_BIT];
      end
      if (wr_sw_res) begin
        sw_res <= 17'(clamp(reg_wdata, sdcf_pkg::RES_MIN,
                            sdcf_pkg::RES_MAX));
      end
      if (wr_sw_cur) begin
        sw_cur <= 14'(clamp(reg_wdata, sdcf_pkg::CUR_MIN,
                            sdcf_pkg::CUR_MAX));
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // switch decode
  logic [2:0] res_index;
  logic [16:0] res_now;
  logic [13:0] dyn_cur;
  logic [13:0] half_cur;
  logic [13:0] sixty_cur;
  logic [13:0] stand_cur;
  logic [13:0] idle_cur;

  // off positions add to the index
  assign res_index = ~res_bits;
  assign res_now = !group_on ? sdcf_pkg::RES_DECADE[res_index] :
                   (res_index == 3'h0) ? sw_res :
                   17'(sdcf_pkg::RES_BASE << res_index);
  assign dyn_cur = (cur_bits == 3'h0) ? sw_cur :
                   sdcf_pkg::CUR_TABLE[cur_bits];
  assign half_cur = dyn_cur >> 1;
  assign sixty_cur = 14'((15'(dyn_cur) * 15'd3) / 15'd5);
  assign stand_cur = stand_on ? dyn_cur : half_cur;
  // never idle above sixty percent, half stays half
  assign idle_cur = (stand_cur < sixty_cur) ? stand_cur : sixty_cur;

  //////////////////////////////////////////////////////////////////////////
  // step decode
  logic step_q;
  logic dir_q;
  logic ena_q;
  logic step_rise;
  logic step_fall;
  logic dir_edge;
  logic step_active;
  logic dir_active;
  logic clockwise_pulse;
  logic counterclockwise_pulse;
  logic accepted;
  logic fault_any;
  logic [10:0] level_age;
  logic [10:0] dir_age;
  logic [10:0] ena_age;
  logic width_bad;
  logic setup_bad;
  logic ena_bad;
  logic [29:0] idle_cnt;

  assign step_rise = step_s && !step_q;
  assign step_fall = !step_s && step_q;
  assign dir_edge = dir_s != dir_q;
  assign step_active = ctrl_falling ? step_fall : step_rise;
  assign dir_active = dir_edge && (ctrl_falling ? !dir_s : dir_s);
  assign clockwise_pulse = ctrl_dual ? step_active : step_active && dir_s;
  assign counterclockwise_pulse = ctrl_dual ? dir_active :
                                  step_active && !dir_s;
  assign fault_any = fault_oc || fault_ov || fault_pe;
  // stage runs only when enabled and healthy
  assign running = ena_s && !fault_any;
  // coincident pulses in dual mode cancel out
  assign accepted = running && (clockwise_pulse ^ counterclockwise_pulse);
  assign width_bad = (step_rise || step_fall) && level_age < PULSE_LIM - 1;
  // direction setup before the step edge
  assign setup_bad = !ctrl_dual && step_active && dir_age < SETUP_LIM - 1;
  assign ena_bad = !ctrl_dual && dir_edge && ena_age < SETUP_LIM - 1;
  assign idle = idle_cnt == IDLE_CYCLES;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_q <= 1'b0;
      dir_q <= 1'b0;
      ena_q <= 1'b0;
      level_age <= SETUP_LIM;
      dir_age <= SETUP_LIM;
      ena_age <= SETUP_LIM;
      timing_error <= 1'b0;
    end else begin
      step_q <= step_s;
      dir_q <= dir_s;
      ena_q <= ena_s;
      level_age <= (step_rise || step_fall) ? 11'h000 :
                   sat_inc(level_age, SETUP_LIM);
      dir_age <= dir_edge ? 11'h000 : sat_inc(dir_age, SETUP_LIM);
      ena_age <= (ena_s != ena_q) ? 11'h000 : sat_inc(ena_age, SETUP_LIM);
      // a new violation beats a clear in the same cycle
      timing_error <= (timing_error && !clear_timing) || width_bad ||
                      setup_bad || ena_bad;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_cnt <= 30'h0000_0000;
      position <= 32'h0000_0000;
    end else begin
      if (accepted) begin
        idle_cnt <= 30'h0000_0000;
      end else if (!idle) begin
        idle_cnt <= idle_cnt + 30'd1;
      end
      if (accepted) begin
        position <= clockwise_pulse ? position + 32'd1 : position - 32'd1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // faults and outputs
  logic [2:0] flash_count;

  assign flash_count = fault_oc ? 3'h1 : fault_ov ? 3'h2 :
                       fault_pe ? 3'h4 : 3'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_oc <= 1'b0;
      fault_ov <= 1'b0;
      fault_pe <= 1'b0;
      stage_enable <= 1'b0;
      step_strobe <= 1'b0;
      step_clockwise <= 1'b0;
      current_command_ma <= 14'h0000;
      standstill_current_ma <= 14'h0000;
      resolution_steps <= 17'h0_0000;
    end else begin
      // latched until power-up, no clear path
      fault_oc <= fault_oc || oc_s;
      fault_ov <= fault_ov || ov_s;
      fault_pe <= fault_pe || pe_s;
      stage_enable <= running;
      step_strobe <= accepted;
      if (accepted) begin
        step_clockwise <= clockwise_pulse;
      end
      // reduced current while idle, shaft free on fault
      current_command_ma <= !running ? 14'h0000 : idle ? idle_cur : dyn_cur;
      standstill_current_ma <= stand_cur;
      resolution_steps <= res_now;
    end
  end

  sdcf_lamp #(
    .PERIOD_CYCLES(LAMP_PERIOD_CYCLES),
    .ON_CYCLES(LAMP_ON_CYCLES),
    .OFF_CYCLES(LAMP_OFF_CYCLES)
  ) u_lamp (
    .clk(clk),
    .rst(rst),
    .flash_count(flash_count),
    .lamp(fault_lamp)
  );
endmodule

// ---- testbench/sdcf_ctrl_model.sv ----
`timescale 1ns/10ps
module sdcf_ctrl_model (
  input wire logic clk,
  output logic step_pulse_in,
  output logic direction_in,
  output logic drive_enable_in
);
  // small margin over the least times
  localparam int HOLD = sdcf_pkg::PULSE_MIN_CYC + 2;
  localparam int SETUP = sdcf_pkg::DIR_SETUP_CYC + 2;
  initial begin
    step_pulse_in = 1'b0;
    direction_in = 1'b1;
    drive_enable_in = 1'b1;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic set_enable(input logic v);
    @(posedge clk);
    drive_enable_in <= v;
    wait_cyc(SETUP);
  endtask
  task automatic pulse_step();
    @(posedge clk);
    step_pulse_in <= 1'b1;
    wait_cyc(HOLD);
    step_pulse_in <= 1'b0;
    wait_cyc(HOLD);
  endtask
  // ccw pulse on the direction line
  task automatic pulse_dir();
    @(posedge clk);
    direction_in <= 1'b1;
    wait_cyc(HOLD);
    direction_in <= 1'b0;
    wait_cyc(HOLD);
  endtask
  task automatic step(input logic cw);
    if (direction_in !== cw) begin
      @(posedge clk);
      direction_in <= cw;
      wait_cyc(SETUP);
    end
    pulse_step();
  endtask
endmodule

// ---- testbench/sdcf_top_sva.sv ----
`timescale 1ns/10ps
module sdcf_top_sva #(
  parameter logic [29:0] LAMP_PERIOD_CYCLES = 30'(sdcf_pkg::LAMP_PERIOD_CYC),
  parameter logic [29:0] LAMP_ON_CYCLES = 30'(sdcf_pkg::LAMP_ON_CYC),
  parameter logic [29:0] LAMP_OFF_CYCLES = 30'(sdcf_pkg::LAMP_OFF_CYC)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic drive_enable_in,
  input wire logic overcurrent_detect,
  input wire logic overvoltage_detect,
  input wire logic phase_error_detect,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic fault_lamp,
  input wire logic stage_enable,
  input wire logic step_strobe,
  input wire logic [13:0] current_command_ma
);
  localparam logic [29:0] GAP1 = LAMP_PERIOD_CYCLES - LAMP_ON_CYCLES;
  localparam logic [29:0] GAP2 = GAP1 - LAMP_ON_CYCLES - LAMP_OFF_CYCLES;
  localparam logic [29:0] GAP4 = GAP2 - 30'd2 * (LAMP_ON_CYCLES +
    LAMP_OFF_CYCLES);
  logic [29:0] lit_cnt;
  logic [29:0] dark_cnt;
  logic seen_fault;
  // first flash after a fault has no defined gap, so it is skipped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lit_cnt <= '0;
      dark_cnt <= '0;
      seen_fault <= 1'b0;
    end else begin
      lit_cnt <= fault_lamp ? lit_cnt + 30'h1 : '0;
      dark_cnt <= fault_lamp ? '0 : dark_cnt + 30'h1;
      seen_fault <= seen_fault | fault_lamp;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  chk_strobe_single: assert property (step_strobe |=> !step_strobe)
    else $error("step strobe longer than one cycle");
  chk_fault_frees: assert property ((overcurrent_detect ||
    overvoltage_detect || phase_error_detect) |-> ##[1:6] !stage_enable)
    else $error("fault did not free the shaft");
  chk_fault_latched: assert property (seen_fault |->
    !stage_enable && current_command_ma == 14'h0000)
    else $error("fault not held until reset");
  chk_enable_low: assert property (!drive_enable_in [*5] |->
    !stage_enable)
    else $error("stage driving while enable low");
  chk_step_refused: assert property (!drive_enable_in [*5] |->
    !step_strobe)
    else $error("step accepted while disabled");
  chk_lamp_on_len: assert property ($fell(fault_lamp) |->
    lit_cnt == LAMP_ON_CYCLES)
    else $error("lamp flash length wrong");
  chk_lamp_gap: assert property ($rose(fault_lamp) && seen_fault |->
    dark_cnt == LAMP_OFF_CYCLES || dark_cnt == GAP1 ||
    dark_cnt == GAP2 || dark_cnt == GAP4)
    else $error("lamp dark gap wrong");
  chk_rdata_quiet: assert property (!reg_read |=>
    reg_rdata == 32'h0000_0000)
    else $error("read data without a read");
endmodule
////////////////////////////////////////////////////////////////////////////
bind sdcf_top sdcf_top_sva #(
  .LAMP_PERIOD_CYCLES(LAMP_PERIOD_CYCLES),
  .LAMP_ON_CYCLES(LAMP_ON_CYCLES),
  .LAMP_OFF_CYCLES(LAMP_OFF_CYCLES)
) i_sva (
  .clk(clk), .rst(rst), .drive_enable_in(drive_enable_in),
  .overcurrent_detect(overcurrent_detect),
  .overvoltage_detect(overvoltage_detect),
  .phase_error_detect(phase_error_detect),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .fault_lamp(fault_lamp),
  .stage_enable(stage_enable), .step_strobe(step_strobe),
  .current_command_ma(current_command_ma)
);

// ---- testbench/stepper_drive_config_and_fault_test.sv ----
`timescale 1ns/10ps
module stepper_drive_config_and_fault_test;
  localparam logic [29:0] IDLE = 30'hfa0;
  localparam logic [29:0] PER = 30'h190;
  localparam int NF [3] = '{4, 2, 1};
  localparam logic [2:0] FV [3] = '{3'h4, 3'h6, 3'h7};
  logic clk, rst, ss, oc, ov, pe, reg_write, reg_read, last;
  logic [3:0] res_sw;
  logic [2:0] cur_sw;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, d;
  logic [13:0] dyn;
  wire logic [31:0] reg_rdata;
  wire logic fault_lamp, stage_enable, step_strobe, step_clockwise;
  wire logic step_pulse_in, direction_in, drive_enable_in;
  wire logic [13:0] current_command_ma, standstill_current_ma;
  wire logic [16:0] resolution_steps;
  int error_cnt = 0, n_checks = 0, strobes = 0, at_fall = 0, fl;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  sdcf_ctrl_model i_ctrl (.clk(clk), .step_pulse_in(step_pulse_in),
    .direction_in(direction_in), .drive_enable_in(drive_enable_in));
  sdcf_top #(.IDLE_CYCLES(IDLE), .LAMP_PERIOD_CYCLES(PER),
    .LAMP_ON_CYCLES(30'h14), .LAMP_OFF_CYCLES(30'h1e)) i_dut (
    .clk(clk), .rst(rst), .current_select_bit0(cur_sw[0]),
    .current_select_bit1(cur_sw[1]), .current_select_bit2(cur_sw[2]),
    .standstill_select(ss), .resolution_select_bit0(res_sw[0]),
    .resolution_select_bit1(res_sw[1]), .resolution_select_bit2(res_sw[2]),
    .resolution_group_select(res_sw[3]), .step_pulse_in(step_pulse_in),
    .direction_in(direction_in), .drive_enable_in(drive_enable_in),
    .overcurrent_detect(oc), .overvoltage_detect(ov),
    .phase_error_detect(pe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .fault_lamp(fault_lamp), .stage_enable(stage_enable),
    .step_strobe(step_strobe), .step_clockwise(step_clockwise),
    .current_command_ma(current_command_ma),
    .standstill_current_ma(standstill_current_ma),
    .resolution_steps(resolution_steps));
  always @(posedge clk) begin
    if (step_strobe === 1'b1) strobes++;
  end
  // strobe count at the falling pin edge tells which edge was taken
  always @(negedge step_pulse_in) at_fall = strobes;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    cyc(6);
  endtask
  // detector levels come from the caller, one per pin
  task automatic set_fault(input logic [2:0] f);
    oc <= f[0];
    ov <= f[1];
    pe <= f[2];
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic set_sw(input logic [3:0] r, input logic [2:0] c,
                        input logic s);
    @(posedge clk);
    res_sw <= r;
    cur_sw <= c;
    ss <= s;
    cyc(6);
  endtask
  function automatic logic [16:0] exp_res(input logic [3:0] r);
    logic [2:0] n;
    n = ~r[2:0];
    if (!r[3]) return sdcf_pkg::RES_DECADE[n];
    if (n == 3'h0) return sdcf_pkg::SW_RES_RESET;
    return sdcf_pkg::RES_BASE << n;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (50000) @(posedge clk);
    error_cnt++;
    $display("CHECK FAILED watchdog expected end seen hang");
    end_sim();
  end
  initial begin
    rst = 1'b1;
    {res_sw, cur_sw, ss} = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    set_fault(3'h0);
    reg_addr = '0;
    reg_wdata = '0;
    do_reset();
    for (int i = 0; i < 16; i++) begin
      set_sw(4'(i), 3'h1, 1'b1);
      check("resolution", 32'(resolution_steps), 32'(exp_res(4'(i))));
    end
    for (int i = 0; i < 16; i++) begin
      set_sw(4'hf, 3'(i >> 1), i[0]);
      dyn = (i < 2) ? sdcf_pkg::SW_CUR_RESET : sdcf_pkg::CUR_TABLE[i >> 1];
      check("standstill", 32'(standstill_current_ma), i[0] ? 32'(dyn) : 32'(dyn >> 1));
    end
    rd(sdcf_pkg::REG_CONTROL, d);
    check("control reset", d, 32'h0000_0000);
    rd(5'h1c, d);
    check("unmapped", d, 32'h0000_0000);
    wr(sdcf_pkg::REG_SW_RESOLUTION, 32'h0003_0000);
    rd(sdcf_pkg::REG_SW_RESOLUTION, d);
    check("sw resolution", d, 32'h0001_9000);
    check("resolution", 32'(resolution_steps), 32'h0001_9000);
    wr(sdcf_pkg::REG_RESOLUTION, 32'h0000_0000);
    rd(sdcf_pkg::REG_RESOLUTION, d);
    check("resolution ro", d, 32'h0001_9000);
    wr(sdcf_pkg::REG_SW_CURRENT, 32'h0000_0064);
    set_sw(4'hf, 3'h0, 1'b1);
    check("sw current", 32'(standstill_current_ma), 32'h0000_01f4);
    set_sw(4'hf, 3'h7, 1'b1);
    i_ctrl.step(1'b1);
    check("strobes", strobes, 1);
    check("rising edge", at_fall, 1);
    check("clockwise", 32'(step_clockwise), 32'h1);
    check("dynamic", 32'(current_command_ma), 32'h0000_206c);
    cyc(IDLE);
    check("idle", 32'(current_command_ma), 32'h0000_1374);
    i_ctrl.step(1'b0);
    check("ccw", 32'(step_clockwise), 32'h0);
    check("strobes ccw", strobes, 2);
    check("restored", 32'(current_command_ma), 32'h0000_206c);
    set_sw(4'hf, 3'h7, 1'b0);
    cyc(IDLE);
    check("idle half", 32'(current_command_ma), 32'h0000_1036);
    wr(sdcf_pkg::REG_CONTROL, 32'h0000_0001);
    i_ctrl.pulse_step();
    check("dual cw", 32'(step_clockwise), 32'h1);
    i_ctrl.pulse_dir();
    check("dual ccw", 32'(step_clockwise), 32'h0);
    check("dual strobes", strobes, 4);
    wr(sdcf_pkg::REG_CONTROL, 32'h0000_0002);
    i_ctrl.step(1'b1);
    check("falling edge", at_fall, strobes - 1);
    i_ctrl.set_enable(1'b0);
    i_ctrl.step(1'b0);
    check("disabled", 32'(stage_enable), 32'h0);
    check("disabled strobes", strobes, 5);
    check("disabled current", 32'(current_command_ma), 32'h0);
    i_ctrl.set_enable(1'b1);
    check("enabled", 32'(stage_enable), 32'h1);
    rd(sdcf_pkg::REG_POSITION, d);
    check("position", d, 32'h0000_0001);
    for (int k = 0; k < 3; k++) begin
      do_reset();
      @(posedge clk);
      set_fault(FV[k]);
      cyc(10);
      set_fault(3'h0);
      cyc(PER);
      fl = 0;
      last = fault_lamp;
      for (int j = 0; j < PER; j++) begin
        cyc(1);
        if (fault_lamp === 1'b1 && last === 1'b0) fl++;
        last = fault_lamp;
      end
      check("flashes", 32'(fl), 32'(NF[k]));
      check("freed", 32'(stage_enable), 32'h0);
      rd(sdcf_pkg::REG_STATUS, d);
      check("fault latch", 32'(d[2:0]), 32'(FV[k]));
    end
    do_reset();
    check("power cycle", {30'h0, stage_enable, fault_lamp}, 32'h2);
    end_sim();
  end
endmodule
